// ### rtl/cfacd_decoder.v
// Flow and ALU clause word decoder with an AXI4-Lite register front end
`timescale 1ns/1ps
`include "cfacd_defs.vh"

// How it works
// - Wait-for-acks stalls while outstanding acks exceed address
// - Texture acked fetch needs active condition, illegal otherwise
// - Vertex acked fetch, texture cache fallback, active only
// - Indexed jump, up to 256 entries, empty jumps away
// - Chip sync waits for whole chip
// - Stop halts thread until rewritten when idle
// - Bit 30 runs as if all lanes valid
// - Bit 31 barrier waits for earlier flow instructions on clause pairs and acked fetches
// - Clause address is byte bits 24:3 plus base
// - Bank numbers at 25:22, 29:26 in both words
// - Two-bit lock modes: none, one, two, loop-offset
// - Eight-bit line addresses at 9:2 and 17:10
// - Count field is slots minus one
// - Alternate constants map to paired thread type
// - Opcode 8 predicates update lanes, not stack
// - Opcodes 9,10,11,15 push, pop, double pop, else
// - Opcode 12 starts extended pair with extra sets
// - Opcode 13 disables masked lanes this iteration
// - Opcode 14 disables masked lanes for whole loop
// - Index selects: none, index zero, index one, invalid
// - Indexed locks of banks 14, 15 ignored
// - Bit 20 treats invalid lanes as inactive
module cfacd_decoder (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Sequencer state inputs
   input wire [23:0] outstanding_acks,
   input wire chip_sync_done,
   input wire prior_flow_done,
   input wire prior_fetch_done,
   input wire seq_idle,
   input wire vertex_cache_present,
   input wire any_lane_enabled,
   input wire [7:0] loop_index_value,
   input wire [2:0] thread_type,
   // Decoded outputs
   output reg [31:0] clause_addr_q,
   output reg [7:0] clause_slots_q,
   output reg [2:0] stack_cmd_q,
   output reg pred_lane_only_q,
   output reg pred_iter_disable_q,
   output reg pred_loop_disable_q,
   output reg all_lanes_valid_mode_q,
   output reg valid_lanes_only_q,
   output reg [2:0] const_thread_q,
   output reg [3:0] lock_req_q,
   output reg [7:0] use_texture_cache_q,
   output wire thread_stall,
   output reg thread_halted_q,
   output reg illegal_q
);

   // Upper flow opcode range check, used by the flow decode
   function is_upper_flow;
      input [7:0] op;
      begin
         is_upper_flow = (op >= `CFACD_OP_WAIT_ACKS) && (op <= `CFACD_OP_STOP);
      end
   endfunction

   // Line address for a lock, offset by loop index bits 7:4 when mode is 3
   function [8:0] lock_line;
      input [1:0] mode;
      input [7:0] line;
      input [7:0] loop;
      begin
         lock_line = (mode == 2'h3) ? ({1'b0, line} + {5'h00, loop[7:4]}) : {1'b0, line};
      end
   endfunction

   // Software-written words, and the jump table index latched by decode
   reg [31:0] word0_q; // First word of pair
   reg [31:0] word1_q; // Second word of pair
   reg [31:0] ext0_q; // Extension low word
   reg [31:0] ext1_q; // Extension high word
   reg [31:0] ctrl_q; // Base address of program
   reg [7:0] jt_index_q; // Selected jump table index
   reg [2:0] stack_cmd_d;
   reg wr_aw_q; // Write address taken
   reg wr_w_q; // Write data taken
   reg [7:0] wr_addr_q;
   reg [31:0] wr_data_q;
   reg is_alu_q; // Last decode was a clause pair
   reg [7:0] line_q [0:3]; // Lock line per set
   reg [3:0] bank_q [0:3]; // Lock bank per set
   reg [1:0] mode_q [0:3]; // Lock mode per set
   reg [1:0] bidx_q [0:3]; // Bank index select per set
   reg flow_wait_q; // Waiting for acks or sync or barrier
   reg [7:0] flow_op_q;
   reg [31:0] flow_w0_q;
   reg barrier_q;
   wire wr_fire;
   wire [7:0] flow_op;
   wire [3:0] alu_op;
   wire [8:0] line_eff [0:3];
   integer k;

   // Write channel accepts each half once until response is out
   assign s_axi_awready = !wr_aw_q && !s_axi_bvalid;
   assign s_axi_wready = !wr_w_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = wr_aw_q && wr_w_q;
   assign flow_op = word1_q[`CFACD_FLOW_OP_HI:`CFACD_FLOW_OP_LO];
   assign alu_op = word1_q[`CFACD_ALU_OP_LO+3:`CFACD_ALU_OP_LO];

   // Stall while waiting on acks, sync, barrier or halt
   assign thread_stall = flow_wait_q || thread_halted_q;

   // Effective lock line per set, for the lock register reads
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_line
         assign line_eff[g] = lock_line(mode_q[g], line_q[g], loop_index_value);
      end
   endgenerate

   // Bus write capture and register update
   always @(posedge ref_clk) begin
      if (rst) begin
         wr_aw_q <= 1'b0;
         wr_w_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         word0_q <= 32'h00000000;
         word1_q <= 32'h00000000;
         ext0_q <= 32'h00000000;
         ext1_q <= 32'h00000000;
         ctrl_q <= 32'h00000000;
      end else begin
         // Address and data in either order
         if (s_axi_awvalid && s_axi_awready) begin
            wr_aw_q <= 1'b1;
            wr_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_w_q <= 1'b1;
            wr_data_q <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_fire) begin
            wr_aw_q <= 1'b0;
            wr_w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            // Byte strobes ignored on purpose; whole words only
            case (wr_addr_q)
               `CFACD_REG_WORD0: word0_q <= wr_data_q;
               `CFACD_REG_WORD1: word1_q <= wr_data_q;
               `CFACD_REG_CTRL: ctrl_q <= wr_data_q;
               `CFACD_REG_LOCK01: ext0_q <= wr_data_q;
               `CFACD_REG_LOCK23: ext1_q <= wr_data_q;
               `CFACD_REG_CMD: begin
                  // Decode strobe, no stored value
               end
               default: s_axi_bresp <= 2'h2; // Unmapped: slave error
            endcase
         end
      end
   end

   // Decode and sequence state, launched by a command write
   always @(posedge ref_clk) begin
      if (rst) begin
         clause_addr_q <= 32'h00000000;
         clause_slots_q <= 8'h00;
         stack_cmd_q <= `CFACD_STK_NONE;
         pred_lane_only_q <= 1'b0;
         pred_iter_disable_q <= 1'b0;
         pred_loop_disable_q <= 1'b0;
         all_lanes_valid_mode_q <= 1'b0;
         valid_lanes_only_q <= 1'b0;
         const_thread_q <= `CFACD_THR_PIXEL;
         lock_req_q <= 4'h0;
         use_texture_cache_q <= 8'h00;
         thread_halted_q <= 1'b0;
         illegal_q <= 1'b0;
         is_alu_q <= 1'b0;
         jt_index_q <= 8'h00;
         flow_wait_q <= 1'b0;
         flow_op_q <= 8'h00;
         flow_w0_q <= 32'h00000000;
         barrier_q <= 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            line_q[k] <= 8'h00;
            bank_q[k] <= 4'h0;
            mode_q[k] <= 2'h0;
            bidx_q[k] <= 2'h0;
         end
      end else begin
         // Release the wait once its condition clears
         if (flow_wait_q) begin
            case (flow_op_q)
               `CFACD_OP_WAIT_ACKS: if (outstanding_acks <= flow_w0_q[23:0]) flow_wait_q <= 1'b0;
               `CFACD_OP_CHIP_SYNC: if (chip_sync_done) flow_wait_q <= 1'b0;
               `CFACD_OP_TEX_ACK, `CFACD_OP_VTX_ACK:
                  if (prior_fetch_done && (!barrier_q || prior_flow_done)) flow_wait_q <= 1'b0;
               default: if (prior_flow_done) flow_wait_q <= 1'b0;
            endcase
         end
         // Halt clears only on a rewrite while idle
         if (thread_halted_q && wr_fire && wr_addr_q == `CFACD_REG_WORD1 && seq_idle &&
            wr_data_q[`CFACD_FLOW_OP_HI:`CFACD_FLOW_OP_LO] != `CFACD_OP_STOP) begin
            thread_halted_q <= 1'b0;
         end
         if (wr_fire && wr_addr_q == `CFACD_REG_CMD && !thread_halted_q && !flow_wait_q) begin
            is_alu_q <= wr_data_q[0];
            barrier_q <= word1_q[`CFACD_BIT_BARRIER];
            all_lanes_valid_mode_q <= word1_q[`CFACD_BIT_ALL_LANES];
            illegal_q <= 1'b0;
            stack_cmd_q <= `CFACD_STK_NONE;
            pred_lane_only_q <= 1'b0;
            pred_iter_disable_q <= 1'b0;
            pred_loop_disable_q <= 1'b0;
            lock_req_q <= 4'h0;
            if (wr_data_q[0]) begin
               // Clause pair: address, locks, count, opcode
               flow_op_q <= 8'h00; // Barrier wait on a clause releases on prior flow done
               clause_addr_q <= ctrl_q + {7'h00, word0_q[`CFACD_ADDR_HI:0], 3'h0};
               clause_slots_q <= {1'b0, word1_q[`CFACD_COUNT_LO+6:`CFACD_COUNT_LO]} + 8'h01;
               valid_lanes_only_q <= 1'b0;
               bank_q[0] <= word0_q[`CFACD_BANK0_LO+3:`CFACD_BANK0_LO];
               bank_q[1] <= word0_q[`CFACD_BANK1_LO+3:`CFACD_BANK1_LO];
               mode_q[0] <= word0_q[`CFACD_MODE0_LO+1:`CFACD_MODE0_LO];
               mode_q[1] <= word1_q[`CFACD_MODE1_LO+1:`CFACD_MODE1_LO];
               line_q[0] <= word1_q[`CFACD_LINE0_LO+7:`CFACD_LINE0_LO];
               line_q[1] <= word1_q[`CFACD_LINE1_LO+7:`CFACD_LINE1_LO];
               // Extension fields count only for the extended pair
               if (alu_op == `CFACD_ALU_EXT_PAIR) begin
                  bank_q[2] <= ext0_q[`CFACD_BANK0_LO+3:`CFACD_BANK0_LO];
                  bank_q[3] <= ext0_q[`CFACD_BANK1_LO+3:`CFACD_BANK1_LO];
                  mode_q[2] <= ext0_q[`CFACD_MODE0_LO+1:`CFACD_MODE0_LO];
                  mode_q[3] <= ext1_q[`CFACD_MODE1_LO+1:`CFACD_MODE1_LO];
                  line_q[2] <= ext1_q[`CFACD_LINE0_LO+7:`CFACD_LINE0_LO];
                  line_q[3] <= ext1_q[`CFACD_LINE1_LO+7:`CFACD_LINE1_LO];
                  for (k = 0; k < 4; k = k + 1) begin
                     bidx_q[k] <= ext0_q[`CFACD_BIDX0_LO+2*k +: 2];
                  end
               end else begin
                  mode_q[2] <= 2'h0;
                  mode_q[3] <= 2'h0;
                  for (k = 0; k < 4; k = k + 1) begin
                     bidx_q[k] <= `CFACD_IDX_NONE;
                  end
               end
               // Lock request per set, dropping indexed banks 14 and 15
               for (k = 0; k < 4; k = k + 1) begin
                  if (k < 2) begin
                     lock_req_q[k] <= (word0_q[`CFACD_MODE0_LO+1:`CFACD_MODE0_LO] != 2'h0 && k == 0) ||
                        (word1_q[`CFACD_MODE1_LO+1:`CFACD_MODE1_LO] != 2'h0 && k == 1);
                  end else begin
                     lock_req_q[k] <= (alu_op == `CFACD_ALU_EXT_PAIR) &&
                        ((k == 2) ? ext0_q[31:30] != 2'h0 : ext1_q[1:0] != 2'h0);
                  end
                  if (alu_op == `CFACD_ALU_EXT_PAIR && ext0_q[`CFACD_BIDX0_LO+2*k +: 2] != `CFACD_IDX_NONE) begin
                     if ((k == 0 && word0_q[25:23] == 3'h7) || (k == 1 && word0_q[29:27] == 3'h7) ||
                        (k == 2 && ext0_q[25:23] == 3'h7) || (k == 3 && ext0_q[29:27] == 3'h7)) begin
                        lock_req_q[k] <= 1'b0;
                     end
                     if (ext0_q[`CFACD_BIDX0_LO+2*k +: 2] == `CFACD_IDX_INVALID) begin
                        illegal_q <= 1'b1;
                     end
                  end
               end
               // Alternate constants source by thread type
               const_thread_q <= thread_type;
               if (word1_q[`CFACD_ALTERNATE_CONSTANT_SOURCE]) begin
                  case (thread_type)
                     `CFACD_THR_PIXEL: const_thread_q <= `CFACD_THR_VERTEX;
                     `CFACD_THR_VERTEX: const_thread_q <= `CFACD_THR_GEOM;
                     `CFACD_THR_GEOM: const_thread_q <= `CFACD_THR_VERTEX;
                     `CFACD_THR_EXPORT: const_thread_q <= `CFACD_THR_GEOM;
                     default: const_thread_q <= thread_type;
                  endcase
               end
               // Stack effect and predicate behaviour
               case (alu_op)
                  `CFACD_ALU_PLAIN: pred_lane_only_q <= 1'b1;
                  `CFACD_ALU_PUSH_FIRST: stack_cmd_q <= `CFACD_STK_PUSH;
                  `CFACD_ALU_POP_AFTER: stack_cmd_q <= `CFACD_STK_POP1;
                  `CFACD_ALU_DOUBLE_POP: stack_cmd_q <= `CFACD_STK_POP2;
                  `CFACD_ALU_ELSE_AFTER: stack_cmd_q <= `CFACD_STK_ELSE;
                  `CFACD_ALU_EXT_PAIR: pred_lane_only_q <= 1'b1;
                  `CFACD_ALU_LOOP_SKIP: pred_iter_disable_q <= 1'b1;
                  `CFACD_ALU_LOOP_EXIT: pred_loop_disable_q <= 1'b1;
                  default: illegal_q <= 1'b1;
               endcase
               if (word1_q[`CFACD_BIT_BARRIER]) flow_wait_q <= 1'b1;
               if (!word1_q[`CFACD_BIT_BARRIER] && !prior_flow_done) flow_wait_q <= 1'b0;
            end else begin
               // Upper flow opcodes
               flow_op_q <= flow_op;
               flow_w0_q <= word0_q;
               valid_lanes_only_q <= word1_q[`CFACD_BIT_VALID_ONLY];
               clause_addr_q <= ctrl_q + {5'h00, word0_q[23:0], 3'h0};
               clause_slots_q <= {2'h0, word1_q[15:10]} + 8'h01;
               use_texture_cache_q <= 8'h00;
               if (!is_upper_flow(flow_op)) illegal_q <= 1'b1;
               case (flow_op)
                  `CFACD_OP_WAIT_ACKS: flow_wait_q <= (outstanding_acks > word0_q[23:0]);
                  `CFACD_OP_TEX_ACK: begin
                     use_texture_cache_q <= 8'h01;
                     if (word1_q[`CFACD_COND_HI:`CFACD_COND_LO] != `CFACD_COND_ACTIVE) illegal_q <= 1'b1;
                     flow_wait_q <= !prior_fetch_done || (word1_q[`CFACD_BIT_BARRIER] && !prior_flow_done);
                  end
                  `CFACD_OP_VTX_ACK: begin
                     use_texture_cache_q <= {7'h00, !vertex_cache_present};
                     if (word1_q[`CFACD_COND_HI:`CFACD_COND_LO] != `CFACD_COND_ACTIVE) illegal_q <= 1'b1;
                     flow_wait_q <= !prior_fetch_done || (word1_q[`CFACD_BIT_BARRIER] && !prior_flow_done);
                  end
                  `CFACD_OP_JUMP_TABLE: begin
                     jt_index_q <= loop_index_value;
                     if (word0_q[`CFACD_JT_SEL_HI:`CFACD_JT_SEL_LO] > `CFACD_JT_SEL_MAX) illegal_q <= 1'b1;
                     // Next entry, or past the table when no lane is left
                     clause_addr_q <= any_lane_enabled ?
                        ctrl_q + {21'h0, loop_index_value, 3'h0} :
                        ctrl_q + {5'h00, word0_q[23:0], 3'h0};
                  end
                  `CFACD_OP_CHIP_SYNC: flow_wait_q <= !chip_sync_done;
                  `CFACD_OP_STOP: thread_halted_q <= 1'b1;
                  default: flow_wait_q <= word1_q[`CFACD_BIT_BARRIER] && !prior_flow_done;
               endcase
            end
         end
      end
   end

   // Read answers, one cycle after address
   always @(posedge ref_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else begin
         if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `CFACD_REG_WORD0: s_axi_rdata <= word0_q;
               `CFACD_REG_WORD1: s_axi_rdata <= word1_q;
               `CFACD_REG_CTRL: s_axi_rdata <= ctrl_q;
               `CFACD_REG_ACKS: s_axi_rdata <= {8'h00, outstanding_acks};
               `CFACD_REG_STAT: s_axi_rdata <= {16'h0000, jt_index_q, is_alu_q, stack_cmd_q,
                  illegal_q, flow_wait_q, thread_halted_q, all_lanes_valid_mode_q};
               `CFACD_REG_CLAUSE: s_axi_rdata <= clause_addr_q;
               `CFACD_REG_LOCK01: s_axi_rdata <= {10'h000, line_eff[1], line_eff[0], bidx_q[1], bidx_q[0]};
               `CFACD_REG_LOCK23: s_axi_rdata <= {10'h000, line_eff[3], line_eff[2], bidx_q[3], bidx_q[2]};
               `CFACD_REG_CMD: s_axi_rdata <= {16'h0000, bank_q[3], bank_q[2], bank_q[1], bank_q[0]};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
      end
   end

endmodule

// ### rtl/cfacd_defs.vh
// Field positions, opcode codes and mode codes for the flow and clause decoder
`ifndef CFACD_DEFS_VH
`define CFACD_DEFS_VH
// Register map, byte addresses
`define CFACD_REG_WORD0 8'h00
`define CFACD_REG_WORD1 8'h04
`define CFACD_REG_CTRL 8'h08
`define CFACD_REG_ACKS 8'h0c
`define CFACD_REG_STAT 8'h10
`define CFACD_REG_CLAUSE 8'h14
`define CFACD_REG_LOCK01 8'h18
`define CFACD_REG_LOCK23 8'h1c
`define CFACD_REG_CMD 8'h20
// Common bits of the flow and ALU words, and the flow-only valid-lanes bit 20
`define CFACD_BIT_BARRIER 31
`define CFACD_BIT_ALL_LANES 30
`define CFACD_BIT_VALID_ONLY 20
// Flow word 1 opcode and condition fields, flow word 0 jump table select
`define CFACD_FLOW_OP_HI 29
`define CFACD_FLOW_OP_LO 22
`define CFACD_COND_HI 9
`define CFACD_COND_LO 8
`define CFACD_COND_ACTIVE 2'h0
`define CFACD_JT_SEL_HI 26
`define CFACD_JT_SEL_LO 24
`define CFACD_JT_SEL_MAX 3'h5
// Upper flow opcodes
`define CFACD_OP_WAIT_ACKS 8'h1a
`define CFACD_OP_TEX_ACK 8'h1b
`define CFACD_OP_VTX_ACK 8'h1c
`define CFACD_OP_JUMP_TABLE 8'h1d
`define CFACD_OP_CHIP_SYNC 8'h1e
`define CFACD_OP_STOP 8'h1f
// ALU word 0 fields
`define CFACD_ADDR_HI 21
`define CFACD_BANK0_LO 22
`define CFACD_BANK1_LO 26
`define CFACD_MODE0_LO 30
// ALU word 1 fields
`define CFACD_MODE1_LO 0
`define CFACD_LINE0_LO 2
`define CFACD_LINE1_LO 10
`define CFACD_COUNT_LO 18
`define CFACD_ALTERNATE_CONSTANT_SOURCE 25
`define CFACD_ALU_OP_LO 26
// ALU clause opcodes
`define CFACD_ALU_PLAIN 4'h8
`define CFACD_ALU_PUSH_FIRST 4'h9
`define CFACD_ALU_POP_AFTER 4'ha
`define CFACD_ALU_DOUBLE_POP 4'hb
`define CFACD_ALU_EXT_PAIR 4'hc
`define CFACD_ALU_LOOP_SKIP 4'hd
`define CFACD_ALU_LOOP_EXIT 4'he
`define CFACD_ALU_ELSE_AFTER 4'hf
// Extension word fields
`define CFACD_BIDX0_LO 4
`define CFACD_IDX_INVALID 2'h3
`define CFACD_IDX_NONE 2'h0
`define CFACD_BANK_IGN_A 4'he
`define CFACD_BANK_IGN_B 4'hf
// Stack effect codes
`define CFACD_STK_NONE 3'h0
`define CFACD_STK_PUSH 3'h1
`define CFACD_STK_POP1 3'h2
`define CFACD_STK_POP2 3'h3
`define CFACD_STK_ELSE 3'h4
// Thread types for alternate constants
`define CFACD_THR_PIXEL 3'h0
`define CFACD_THR_VERTEX 3'h1
`define CFACD_THR_GEOM 3'h2
`define CFACD_THR_EXPORT 3'h3
`define CFACD_THR_HULL 3'h4
`define CFACD_THR_LOCAL 3'h5
`define CFACD_THR_COMPUTE 3'h6
`endif

// ### verif/cfacd_chk.sv
// Bus handshake and decode stability checks for the clause decoder
`timescale 1ns/1ps
module cfacd_chk (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Bus handshakes
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Decode results
   input wire [31:0] clause_addr_q,
   input wire [7:0] clause_slots_q,
   input wire [2:0] stack_cmd_q,
   input wire pred_lane_only_q,
   input wire pred_iter_disable_q,
   input wire pred_loop_disable_q,
   input wire thread_halted_q,
   input wire thread_stall
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Answers offered, then taken
   sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
   sequence b_take; s_axi_bvalid && s_axi_bready; endsequence
   sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
   sequence r_take; s_axi_rvalid && s_axi_rready; endsequence
   wr_hold_a: assert property (b_wait |=> s_axi_bvalid) else $error("write answer dropped");
   wr_done_a: assert property (b_take |=> !s_axi_bvalid) else $error("write answer repeated");
   rd_hold_a: assert property (r_wait |=> s_axi_rvalid) else $error("read answer dropped");
   rd_done_a: assert property (r_take |=> !s_axi_rvalid) else $error("read answer repeated");
   halt_stall_a: assert property (thread_halted_q |-> thread_stall) else $error("halt not stalling");
   stack_code_a: assert property (stack_cmd_q <= 3'h4) else $error("stack code out of range");
   slot_range_a: assert property (clause_slots_q <= 8'h80) else $error("slot count above range");
   // Results only move when a command completes
   addr_stand_a: assert property (!$rose(s_axi_bvalid) |-> $stable(clause_addr_q) && $stable(stack_cmd_q))
      else $error("decode moved without command");
   pred_one_a: assert property ($onehot0({pred_lane_only_q, pred_iter_disable_q, pred_loop_disable_q}))
      else $error("several predicate modes");
endmodule
bind cfacd_decoder cfacd_chk chk_u (.ref_clk(ref_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .clause_addr_q(clause_addr_q), .clause_slots_q(clause_slots_q), .stack_cmd_q(stack_cmd_q),
   .pred_lane_only_q(pred_lane_only_q), .pred_iter_disable_q(pred_iter_disable_q),
   .pred_loop_disable_q(pred_loop_disable_q), .thread_halted_q(thread_halted_q), .thread_stall(thread_stall));

// ### verif/cfacd_prog_mem.sv
// Program memory model holding flow word pairs for the sequencer
`timescale 1ns/1ps
module cfacd_prog_mem (
   // Fetch port
   input wire [1:0] pc,
   output logic [31:0] w0,
   output logic [31:0] w1
);
   // Lane mode bits are never set together here
   always_comb begin
      case (pc)
         2'h0: begin w0 = 32'h5; w1 = 32'h0680_0000; end // Wait acks, limit 5
         2'h1: begin w0 = 32'h0; w1 = 32'h07c0_0000; end // Stop
         2'h2: begin w0 = 32'h0; w1 = 32'h0300_0000; end // Reserved code
         default: begin w0 = 32'h0; w1 = 32'h4780_0000; end // Chip sync, all lanes
      endcase
   end
endmodule

// ### verif/tb_cf_alu_clause_word_decoder.sv
// Self-checking bench driving the decoder over its register bus
`timescale 1ns/1ps
module tb_cf_alu_clause_word_decoder;
   reg ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, seq_idle, vcp; // Bus and state drives
   reg [7:0] awaddr, araddr, loop_idx;
   reg [31:0] wdata, d;
   reg [23:0] acks; // Outstanding acks seen by decoder
   reg [2:0] thr;
   reg [1:0] pc, r;
   wire awready, wready, bvalid, arready, rvalid, stall, halted, illegal, all_lanes, lane_only, iter_dis, loop_dis;
   wire [1:0] rresp;
   wire [31:0] caddr, rdata, pm_w0, pm_w1;
   wire [7:0] slots, utc;
   wire vlo;
   wire [2:0] stk, cthr;
   wire [3:0] lockq;
   integer errors, checked, i;
   integer cyc = 0;
   // Device under test
   cfacd_decoder dut_u (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .outstanding_acks(acks),
      .chip_sync_done(1'b1), .prior_flow_done(1'b1), .prior_fetch_done(1'b1), .seq_idle(seq_idle),
      .vertex_cache_present(vcp), .any_lane_enabled(1'b1), .loop_index_value(loop_idx),
      .thread_type(thr), .clause_addr_q(caddr), .clause_slots_q(slots), .stack_cmd_q(stk),
      .pred_lane_only_q(lane_only), .pred_iter_disable_q(iter_dis), .pred_loop_disable_q(loop_dis),
      .all_lanes_valid_mode_q(all_lanes), .valid_lanes_only_q(vlo), .const_thread_q(cthr),
      .lock_req_q(lockq), .use_texture_cache_q(utc), .thread_stall(stall), .thread_halted_q(halted),
      .illegal_q(illegal));
   // Program memory partner
   cfacd_prog_mem pm_u (.pc(pc), .w0(pm_w0), .w1(pm_w1));
   // Free running clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Hang guard, generous for a few dozen bus cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         conclude;
      end
   end
   task cmp(input [31:0] g, input [31:0] e);
      begin
         checked = checked + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   // Write: both halves offered, each released when taken; late bready
   task wr(input [7:0] a, input [31:0] v);
      reg ta, tw;
      begin
         @(posedge ref_clk);
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         ta = 0;
         tw = 0;
         while (!(ta && tw)) begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
               awvalid <= 1'b0;
               ta = 1;
            end
            if (wvalid && wready) begin
               wvalid <= 1'b0;
               tw = 1;
            end
         end
         while (!bvalid) @(posedge ref_clk);
         bready <= 1'b1;
         @(posedge ref_clk);
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge ref_clk);
         araddr <= a;
         arvalid <= 1'b1;
         @(posedge ref_clk);
         while (!arready) @(posedge ref_clk);
         arvalid <= 1'b0;
         while (!rvalid) @(posedge ref_clk);
         rready <= 1'b1;
         @(posedge ref_clk);
         r = rresp;
         d = rdata;
         rready <= 1'b0;
      end
   endtask
   // Load a word pair, then issue the decode command
   task dec(input [31:0] a, input [31:0] b, input alu);
      begin
         wr(8'h00, a);
         wr(8'h04, b);
         wr(8'h20, {31'h0, alu});
         #1;
      end
   endtask
   task conclude;
      begin
         $display("checked %0d errors %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready, seq_idle} = 7'h40;
      {awaddr, araddr, loop_idx, wdata, acks, thr, pc, vcp} = 0;
      errors = 0;
      checked = 0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      wr(8'h08, 32'h100);
      // Every clause opcode, widest slot count
      for (i = 8; i < 16; i = i + 1) begin
         dec(32'h94c0_0010, (i << 26) | 32'h01fc_0001, 1'b1);
         cmp(caddr, 32'h180);
         cmp(slots, 8'h80);
         cmp(lockq, 4'h3);
         if (i < 12 || i == 15) cmp(stk, i == 15 ? 4 : i - 8);
         cmp({lane_only, iter_dis, loop_dis}, i == 8 || i == 12 ? 4 : i == 13 ? 2 : i == 14 ? 1 : 0);
      end
      // Paired thread constants with all-lanes mode
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge ref_clk);
         thr <= i;
         dec(32'h10, 32'h6200_0000, 1'b1);
         cmp(cthr, i[0] ? 2 : 1);
         cmp(all_lanes, 1);
      end
      rd(8'h14);
      cmp(d, 32'h180);
      @(posedge ref_clk);
      acks <= 24'd6;
      #1 dec(pm_w0, pm_w1, 1'b0);
      cmp(stall, 1);
      @(posedge ref_clk);
      acks <= 24'd5;
      @(posedge ref_clk);
      #1 cmp(stall, 0);
      // Vertex fetch falls back to texture cache when none is fitted
      dec(32'h0, 32'h0710_0000, 1'b0);
      cmp(utc, 8'h01);
      cmp(vlo, 1);
      vcp <= 1'b1;
      dec(32'h0, 32'h0700_0000, 1'b0);
      cmp(utc, 8'h00);
      cmp(vlo, 0);
      @(posedge ref_clk);
      pc <= 2'h1;
      #1 dec(pm_w0, pm_w1, 1'b0);
      cmp(halted, 1);
      @(posedge ref_clk);
      seq_idle <= 1'b1;
      pc <= 2'h3;
      #1 wr(8'h04, pm_w1);
      #1 cmp(halted, 0);
      @(posedge ref_clk);
      pc <= 2'h2;
      #1 dec(pm_w0, pm_w1, 1'b0);
      cmp(illegal, 1);
      rd(8'h40);
      cmp(r, 2'h2);
      conclude;
   end
endmodule
